// ==== hw/linefeed_defs.vh ====
// Register offsets, field layouts, state codes and timing counts.
`ifndef LINEFEED_DEFS_VH
`define LINEFEED_DEFS_VH
`define OFS_STATE 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_CLR 8'h0c
`define OFS_IRQ_EN 8'h10
`define OFS_LOOP_V 8'h14
`define OFS_LOOP_I 8'h18
`define OFS_LONG_I 8'h1c
`define OFS_TIP_V 8'h20
`define OFS_RING_V 8'h24
`define OFS_TIP_I 8'h28
`define OFS_RING_I 8'h2c
`define OFS_CFG 8'h30
`define ST_OPEN 3'h0
`define ST_FWD_ACT 3'h1
`define ST_REV_ACT 3'h2
`define ST_FWD_OHT 3'h3
`define ST_REV_OHT 3'h4
`define ST_TIP_OPEN 3'h5
`define ST_RING_OPEN 3'h6
`define ST_RINGING 3'h7
`define ST_DIAG 3'h7
`define IRQ_PWR_ALARM 0
`define IRQ_LOOP 1
`define IRQ_GKEY 2
`define CFG_WIDEBAND 0
`define CFG_RING_DC 1
`define CFG_TJ_HIGH 2
`define CFG_DIAG 3
`define CLK_HZ 250000000
`define REFRESH_HZ 2000
`define REFRESH_CYCLES (`CLK_HZ / `REFRESH_HZ)
`endif

// ==== hw/linefeed_state_supervisor.v ====
// Linefeed operating state supervisor with Wishbone register access.
// Notes on behaviour
// - Eight operating states selectable through a software register.
// - After reset the open state holds until software loads another.
// - Open state: leads high impedance, supervision and audio off.
// - A fault forces open state and raises a power alarm.
// - Power alarm interrupt is maskable; forced open is never masked.
// - Triggers: total power, foreign voltage or current, thermal.
// - Active states feed line and audio, with polarity and detection.
// - On-hook transmission states keep feed and audio with polarity.
// - First-lead-open drives only second lead, detection enabled.
// - Second-lead-open drives only first lead, detection enabled.
// - Ringing drives both leads, dc offset as configured.
// - Diagnostics configuration bit enables diagnostic resources in any state.
// - Monitor result registers refresh at 2 kHz or faster.
// - Loop voltage, loop current and longitudinal current derived.
// - Over-temperature at selected threshold forces low-power shutdown.
// - Wideband selection runs audio at 16 kHz, else voice band.
// - Live loop-closure status bit plus maskable loop interrupt bit.
//
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "linefeed_defs.vh"
module linefeed_state_supervisor #(
  parameter ADC_W = 16,
  parameter REFRESH_CYCLES = `REFRESH_CYCLES
) (
  // Clock and reset
  input wire SYS_CLK,
  input wire ARST_N,
  // Wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output wire WB_ACK_O,
  // Fault and detector inputs
  input wire TOTAL_POWER_FAULT,
  input wire FOREIGN_V_FAULT,
  input wire TEMP_OVER_145,
  input wire TEMP_OVER_200,
  input wire LOOP_CLOSED,
  input wire GROUND_KEY,
  // Monitor converter samples
  input wire [ADC_W-1:0] ADC_TIP_V,
  input wire [ADC_W-1:0] ADC_RING_V,
  input wire [ADC_W-1:0] ADC_TIP_I,
  input wire [ADC_W-1:0] ADC_RING_I,
  // Line control
  output reg TIP_DRIVE_EN,
  output reg RING_DRIVE_EN,
  output reg POLARITY_REV,
  output reg SUPERVISION_EN,
  output reg AUDIO_EN,
  output reg RINGING_EN,
  output reg RING_DC_OFFSET_EN,
  output reg DIAG_EN,
  output reg WIDEBAND_16K,
  output reg THERMAL_SHUTDOWN,
  output reg ADC_SAMPLE,
  output wire IRQ
);
  wire rst_n;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  wire [2:0] irq_flags;
  wire [2:0] irq_set;
  wire [2:0] irq_clr;
  reg [2:0] irq_en_reg;
  reg [3:0] cfg_reg;
  reg ack_reg;
  wire loop_rise;
  wire gkey_rise;
  reg [31:0] refresh_cnt_reg;
  reg [ADC_W-1:0] tip_v_reg;
  reg [ADC_W-1:0] ring_v_reg;
  reg [ADC_W-1:0] tip_i_reg;
  reg [ADC_W-1:0] ring_i_reg;
  reg [ADC_W-1:0] loop_v_reg;
  reg [ADC_W-1:0] loop_i_reg;
  reg [ADC_W-1:0] long_i_reg;
  wire [ADC_W:0] long_sum;
  wire over_temp;
  wire fault;
  wire req;
  wire wr;
  wire rd_clr;
  wire sel_state;
  wire sel_irq_en;
  wire sel_cfg;

  // Reset asserts at once but is released two edges after the pin rises,
  // so no flop leaves reset on an edge that the pin release may disturb.
  reset_sync release_sync (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .rst_n(rst_n)
  );

  assign req = WB_CYC_I & WB_STB_I & ~ack_reg;
  assign wr = req & WB_WE_I & WB_SEL_I[0];
  assign WB_ACK_O = ack_reg;
  assign rd_clr = wr && (WB_ADR_I == `OFS_IRQ_CLR);
  assign sel_state = wr && (WB_ADR_I == `OFS_STATE);
  assign sel_irq_en = wr && (WB_ADR_I == `OFS_IRQ_EN);
  assign sel_cfg = wr && (WB_ADR_I == `OFS_CFG);

  // Thermal threshold is picked by configuration.
  assign over_temp = cfg_reg[`CFG_TJ_HIGH] ? TEMP_OVER_200 : TEMP_OVER_145;
  assign fault = TOTAL_POWER_FAULT | FOREIGN_V_FAULT | over_temp;

  // The forced open path has no mask, so high-voltage protection holds
  // even when software has disabled the alarm interrupt.
  always @* begin
    state_next = state_reg;
    if (sel_state)
      state_next = WB_DAT_I[2:0];
    if (fault)
      state_next = `ST_OPEN;
  end

  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `ST_OPEN;
      irq_en_reg <= 3'h0;
      cfg_reg <= 4'h0;
      ack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ack_reg <= req;
      if (sel_irq_en)
        irq_en_reg <= WB_DAT_I[2:0];
      if (sel_cfg)
        cfg_reg <= WB_DAT_I[3:0];
    end
  end

  // Event sources of the three sticky flags; a clear is a write of ones.
  assign irq_set = {gkey_rise, loop_rise, fault};
  assign irq_clr = rd_clr ? WB_DAT_I[2:0] : 3'h0;

  // The delayed copies reset low, the idle level of both detector pins,
  // so no false edge follows reset.
  edge_rise loop_edge (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .level(LOOP_CLOSED),
    .rise(loop_rise)
  );

  edge_rise gkey_edge (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .level(GROUND_KEY),
    .rise(gkey_rise)
  );

  // One sticky flag per interrupt source.
  sticky_flag #(
    .W(1)
  ) alarm_flag (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .set(irq_set[`IRQ_PWR_ALARM]),
    .clr(irq_clr[`IRQ_PWR_ALARM]),
    .flag(irq_flags[`IRQ_PWR_ALARM])
  );

  sticky_flag #(
    .W(1)
  ) loop_flag (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .set(irq_set[`IRQ_LOOP]),
    .clr(irq_clr[`IRQ_LOOP]),
    .flag(irq_flags[`IRQ_LOOP])
  );

  sticky_flag #(
    .W(1)
  ) gkey_flag (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .set(irq_set[`IRQ_GKEY]),
    .clr(irq_clr[`IRQ_GKEY]),
    .flag(irq_flags[`IRQ_GKEY])
  );

  assign IRQ = |(irq_flags & irq_en_reg);

  // Line control decode from the next state, registered so it changes with the state register.
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      TIP_DRIVE_EN <= 1'b0;
      RING_DRIVE_EN <= 1'b0;
      POLARITY_REV <= 1'b0;
      SUPERVISION_EN <= 1'b0;
      AUDIO_EN <= 1'b0;
      RINGING_EN <= 1'b0;
      RING_DC_OFFSET_EN <= 1'b0;
      DIAG_EN <= 1'b0;
      WIDEBAND_16K <= 1'b0;
      THERMAL_SHUTDOWN <= 1'b0;
    end else begin
      TIP_DRIVE_EN <= 1'b0;
      RING_DRIVE_EN <= 1'b0;
      POLARITY_REV <= 1'b0;
      SUPERVISION_EN <= 1'b0;
      AUDIO_EN <= 1'b0;
      RINGING_EN <= 1'b0;
      RING_DC_OFFSET_EN <= 1'b0;
      THERMAL_SHUTDOWN <= over_temp;
      DIAG_EN <= cfg_reg[`CFG_DIAG];
      WIDEBAND_16K <= cfg_reg[`CFG_WIDEBAND] & (state_next != `ST_OPEN);
      case (state_next)
        `ST_OPEN: begin
          TIP_DRIVE_EN <= 1'b0;
        end
        `ST_FWD_ACT, `ST_REV_ACT: begin
          TIP_DRIVE_EN <= 1'b1;
          RING_DRIVE_EN <= 1'b1;
          POLARITY_REV <= (state_next == `ST_REV_ACT);
          SUPERVISION_EN <= 1'b1;
          AUDIO_EN <= 1'b1;
        end
        `ST_FWD_OHT, `ST_REV_OHT: begin
          TIP_DRIVE_EN <= 1'b1;
          RING_DRIVE_EN <= 1'b1;
          POLARITY_REV <= (state_next == `ST_REV_OHT);
          AUDIO_EN <= 1'b1;
        end
        `ST_TIP_OPEN: begin
          RING_DRIVE_EN <= 1'b1;
          SUPERVISION_EN <= 1'b1;
        end
        `ST_RING_OPEN: begin
          TIP_DRIVE_EN <= 1'b1;
          SUPERVISION_EN <= 1'b1;
          POLARITY_REV <= 1'b1;
        end
        `ST_RINGING: begin
          TIP_DRIVE_EN <= 1'b1;
          RING_DRIVE_EN <= 1'b1;
          RINGING_EN <= 1'b1;
          RING_DC_OFFSET_EN <= cfg_reg[`CFG_RING_DC];
        end
        default: begin
          TIP_DRIVE_EN <= 1'b0;
        end
      endcase
    end
  end

  assign long_sum = {1'b0, ADC_TIP_I} + {1'b0, ADC_RING_I};

  // Monitor refresh tick; every result register loads on the same tick.
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      refresh_cnt_reg <= 32'h0;
      ADC_SAMPLE <= 1'b0;
      tip_v_reg <= {ADC_W{1'b0}};
      ring_v_reg <= {ADC_W{1'b0}};
      tip_i_reg <= {ADC_W{1'b0}};
      ring_i_reg <= {ADC_W{1'b0}};
      loop_v_reg <= {ADC_W{1'b0}};
      loop_i_reg <= {ADC_W{1'b0}};
      long_i_reg <= {ADC_W{1'b0}};
    end else begin
      ADC_SAMPLE <= 1'b0;
      if (refresh_cnt_reg >= REFRESH_CYCLES - 1) begin
        refresh_cnt_reg <= 32'h0;
        ADC_SAMPLE <= 1'b1;
        tip_v_reg <= ADC_TIP_V;
        ring_v_reg <= ADC_RING_V;
        tip_i_reg <= ADC_TIP_I;
        ring_i_reg <= ADC_RING_I;
        loop_v_reg <= ADC_TIP_V - ADC_RING_V;
        loop_i_reg <= ADC_TIP_I - ADC_RING_I;
        long_i_reg <= long_sum[ADC_W:1];
      end else begin
        refresh_cnt_reg <= refresh_cnt_reg + 32'h1;
      end
    end
  end

  // Read data; unmapped and write-only offsets read as zero.
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WB_DAT_O <= 32'h0;
    end else if (req && !WB_WE_I) begin
      case (WB_ADR_I)
        `OFS_STATE: WB_DAT_O <= {29'h0, state_reg};
        `OFS_STATUS: WB_DAT_O <= {29'h0, GROUND_KEY, LOOP_CLOSED, fault};
        `OFS_IRQ_STAT: WB_DAT_O <= {29'h0, irq_flags};
        `OFS_IRQ_EN: WB_DAT_O <= {29'h0, irq_en_reg};
        `OFS_CFG: WB_DAT_O <= {28'h0, cfg_reg};
        `OFS_LOOP_V: WB_DAT_O <= {{(32-ADC_W){1'b0}}, loop_v_reg};
        `OFS_LOOP_I: WB_DAT_O <= {{(32-ADC_W){1'b0}}, loop_i_reg};
        `OFS_LONG_I: WB_DAT_O <= {{(32-ADC_W){1'b0}}, long_i_reg};
        `OFS_TIP_V: WB_DAT_O <= {{(32-ADC_W){1'b0}}, tip_v_reg};
        `OFS_RING_V: WB_DAT_O <= {{(32-ADC_W){1'b0}}, ring_v_reg};
        `OFS_TIP_I: WB_DAT_O <= {{(32-ADC_W){1'b0}}, tip_i_reg};
        `OFS_RING_I: WB_DAT_O <= {{(32-ADC_W){1'b0}}, ring_i_reg};
        default: WB_DAT_O <= 32'h0;
      endcase
    end
  end
endmodule

// Two-flop release of the asynchronous reset.
module reset_sync (
  // Clock and raw reset
  input wire clk,
  input wire arst_n,
  // Released reset
  output wire rst_n
);
  reg s1_reg;
  reg s2_reg;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= 1'b1;
      s2_reg <= s1_reg;
    end
  end

  assign rst_n = s2_reg;
endmodule

// Holds a flag from the cycle after its event until software clears it.
module sticky_flag #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Event, clear and flag
  input wire [W-1:0] set,
  input wire [W-1:0] clr,
  output reg [W-1:0] flag
);
  // An event in the same cycle as its clear wins, so no alarm is lost.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= {W{1'b0}};
    end else begin
      flag <= (flag & ~clr) | set;
    end
  end
endmodule

// Single-cycle pulse on each rising edge of a synchronous level.
module edge_rise #(
  parameter IDLE = 1'b0
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Level in, pulse out
  input wire level,
  output wire rise
);
  reg level_d_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_d_reg <= IDLE;
    end else begin
      level_d_reg <= level;
    end
  end

  assign rise = level & ~level_d_reg;
endmodule

// ==== tb/lfs_asserts.sv ====
// Port assertions for the linefeed state supervisor.
`timescale 1ns/1ps
module lfs_asserts #(parameter REFRESH_CYCLES = 8) (
  input wire SYS_CLK, input wire ARST_N,
  input wire WB_CYC_I, input wire WB_STB_I, input wire WB_ACK_O,
  input wire TOTAL_POWER_FAULT, input wire FOREIGN_V_FAULT,
  input wire TEMP_OVER_200, input wire THERMAL_SHUTDOWN,
  input wire TIP_DRIVE_EN, input wire RING_DRIVE_EN,
  input wire SUPERVISION_EN, input wire AUDIO_EN,
  input wire RINGING_EN, input wire ADC_SAMPLE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  logic [31:0] gap_reg;
  wire flt = TOTAL_POWER_FAULT | FOREIGN_V_FAULT;
  // Reset delay of the design is absorbed by the slack of four cycles.
  always @(posedge SYS_CLK or negedge ARST_N)
    if (!ARST_N) gap_reg <= 0;
    else gap_reg <= ADC_SAMPLE ? 0 : gap_reg + 1;
  ack_timing_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    |=> WB_ACK_O) else $error("ack not one cycle after request");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  fault_open_a: assert property (
    flt |=> !TIP_DRIVE_EN && !RING_DRIVE_EN)
    else $error("leads driven after fault");
  fault_quiet_a: assert property (
    flt |=> !AUDIO_EN && !SUPERVISION_EN)
    else $error("audio on after fault");
  thermal_stop_a: assert property (
    TEMP_OVER_200 |-> ##[1:3] THERMAL_SHUTDOWN)
    else $error("no thermal shutdown");
  audio_leads_a: assert property (
    AUDIO_EN |-> TIP_DRIVE_EN && RING_DRIVE_EN)
    else $error("audio without both leads");
  ring_leads_a: assert property (
    RINGING_EN |-> TIP_DRIVE_EN && RING_DRIVE_EN)
    else $error("ringing without both leads");
  sup_leads_a: assert property (
    SUPERVISION_EN |-> TIP_DRIVE_EN || RING_DRIVE_EN)
    else $error("supervision when open");
  refresh_gap_a: assert property (
    gap_reg <= REFRESH_CYCLES + 4)
    else $error("monitor refresh missed");
  cover property (flt);
  cover property (RINGING_EN);
  cover property (THERMAL_SHUTDOWN);
endmodule

// ==== tb/host_model.sv ====
// Wishbone host model that programs the supervisor.
`timescale 1ns/1ps
module host_model (
  input wire clk, input wire ack,
  output logic cyc, output logic stb, output logic we,
  output logic [7:0] adr, output logic [3:0] sel,
  output logic [31:0] dat, output logic tmo
);
  initial {cyc, stb, we, adr, sel, dat, tmo} = 0;
  // The alarm mask never touches the forced open state.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {3'b111 & {2'b11, w}, a, 4'hf, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) tmo <= 1;
    {cyc, stb} <= 2'b00;
  endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the linefeed state supervisor.
`timescale 1ns/1ps
`include "linefeed_defs.vh"
module tb;
  logic clk = 0, rst_n = 0, cyc, stb, we, ack, tmo, irq, smp;
  logic pf = 0, fv = 0, t1 = 0, t2 = 0, lc = 0, gk = 0;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] di, dq;
  logic [15:0] tv = 0, rv = 0, ti = 0, ri = 0;
  logic [9:0] o;
  logic [3:0] tbl [8] = '{4'h0, 4'he, 4'he, 4'he, 4'he, 4'h4, 4'h8, 4'hd};
  logic [31:0] exq [$];
  int failures = 0, comparisons = 0, seed = 99;
  initial forever #2 clk = ~clk;
  host_model host(.clk(clk), .ack(ack), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat(di), .tmo(tmo));
  linefeed_state_supervisor #(.REFRESH_CYCLES(8)) dut(.SYS_CLK(clk),
    .ARST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(di), .WB_DAT_O(dq),
    .WB_ACK_O(ack), .TOTAL_POWER_FAULT(pf), .FOREIGN_V_FAULT(fv),
    .TEMP_OVER_145(t1), .TEMP_OVER_200(t2), .LOOP_CLOSED(lc),
    .GROUND_KEY(gk), .ADC_TIP_V(tv), .ADC_RING_V(rv), .ADC_TIP_I(ti),
    .ADC_RING_I(ri), .TIP_DRIVE_EN(o[9]), .RING_DRIVE_EN(o[8]),
    .POLARITY_REV(o[7]), .SUPERVISION_EN(o[6]), .AUDIO_EN(o[5]),
    .RINGING_EN(o[4]), .RING_DC_OFFSET_EN(o[3]), .DIAG_EN(o[2]),
    .WIDEBAND_16K(o[1]), .THERMAL_SHUTDOWN(o[0]), .ADC_SAMPLE(smp),
    .IRQ(irq));
  task chk(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    host.xfer(1, a, d);
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    exq.push_back(e);
    host.xfer(0, a, 0);
  endtask
  always @(posedge clk) if (ack && !we) chk("rdata", dq, exq.pop_front());
  always @(posedge clk) if (tmo) begin
    failures++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    rd(`OFS_STATE, `ST_OPEN);
    chk("open", o, 0);
    for (int s = 7; s >= 0; s--) begin
      wr(`OFS_STATE, s);
      chk("lines", {o[9:8], o[5:4]}, tbl[s]);
      if (s inside {[1:4]}) chk("pol", o[7], s % 2 == 0);
      if (s != 3 && s != 4 && s != 7) chk("sup", o[6], s inside {1, 2, 5, 6});
      rd(`OFS_STATE, s);
    end
    $display("state table done");
    wr(`OFS_IRQ_EN, 1);
    for (int f = 0; f < 4; f++) begin
      wr(`OFS_STATE, `ST_FWD_ACT);
      {t2, t1, fv, pf} <= (f == 3) ? 4'hc : 4'h1 << f;
      @(posedge clk);
      {t2, t1, fv, pf} <= 0;
      rd(`OFS_STATE, `ST_OPEN);
      chk("irq", irq, 1);
      wr(`OFS_IRQ_EN, 0);
      chk("mask", irq, 0);
      wr(`OFS_IRQ_CLR, 1);
      wr(`OFS_IRQ_EN, 1);
      chk("clear", irq, 0);
    end
    wr(`OFS_CFG, 32'h4);
    wr(`OFS_STATE, `ST_FWD_ACT);
    t1 <= 1;
    repeat (3) @(posedge clk);
    chk("tj200", o[0], 0);
    rd(`OFS_STATE, `ST_FWD_ACT);
    t2 <= 1;
    repeat (3) @(posedge clk);
    chk("shutdown", o[0], 1);
    {t2, t1} <= 0;
    rd(`OFS_STATE, `ST_OPEN);
    wr(`OFS_IRQ_CLR, 1);
    $display("fault sources done");
    {tv, rv, ti, ri} <= {$random(seed), $random(seed)};
    repeat (20) @(posedge clk);
    rd(`OFS_TIP_V, tv);
    rd(`OFS_LOOP_V, 16'(tv - rv));
    rd(`OFS_LOOP_I, 16'(ti - ri));
    rd(`OFS_LONG_I, 17'(ti + ri) >> 1);
    rd(8'hfc, 0);
    $display("monitor done");
    wr(`OFS_CFG, 32'hb);
    wr(`OFS_STATE, `ST_RINGING);
    chk("cfg", o[3:1], 3'h7);
    {lc, gk} <= 2'b11;
    repeat (2) @(posedge clk);
    rd(`OFS_STATUS, 6);
    rd(`OFS_IRQ_STAT, 6);
    $display("config and detectors done");
    end_of_test;
  end
endmodule
bind linefeed_state_supervisor lfs_asserts
  #(.REFRESH_CYCLES(REFRESH_CYCLES)) checker_i(.*);
